/* src/stc_pkg.sv */
// package of constants and types for the sixteen-bit timer counter
// Notes on behaviour
// [RQ1] A 16-bit counter steps by one, up or down by mode, on each active timer clock edge while counting.
// [RQ2] Active counter edges come from the global tick divided by a prescale of 1, 8, 32 or 128.
// [RQ3] Reading the counter low byte copies the counter's upper byte into a holding register for later upper-byte reads.
// [RQ4] Software reads the low byte before the upper byte so both come from one sample.
// [RQ5] Any write to the counter low byte clears the whole counter, whatever the data.
// [RQ6] A nonzero counting mode starts the counter and mode 00 halts it at its present value.
// [RQ7] Free-running mode counts up from 0x0000 and after 0xFFFF loads 0x0000 on the next tick.
// [RQ8] Free-running mode sets the overflow flag when the counter reaches 0xFFFF.
// [RQ9] Modulo mode counts up to the period compare value, then loads 0x0000 on the next tick.
// [RQ10] Modulo mode sets the overflow flag when the counter reaches the period compare value.
// [RQ11] Up/down mode counts up to the period compare value, down to 0x0000, and repeats.
// [RQ12] Up/down mode sets the overflow flag on return to 0x0000, not at the upper turn.
// [RQ13] The cpu timer flag rises on overflow only with the overflow mask set; the overflow flag sets anyway.
// [RQ14] An interrupt request goes out only when both the overflow mask and the timer enable are one.
// [RQ15] Mode 00 halts, 01 free-runs, 10 modulo, 11 up/down; prescale 00..11 divide by 1, 8, 32, 128.
// [RQ16] After reset the counter is 0x0000, halted, overflow flag clear, prescale divide by one.
package stc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CNT_LOW = 8'h00;
   localparam logic [7:0] ADDR_CNT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_CMP_LOW = 8'h0c;
   localparam logic [7:0] ADDR_CMP_HIGH = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
   localparam logic [7:0] ADDR_TICK_SPEED = 8'h20;
   // field positions
   localparam int MODE_LSB = 0;
   localparam int DIV_LSB = 2;
   localparam int OVF_BIT = 0;
   localparam int CPU_BIT = 1;
   // counting modes
   localparam logic [1:0] MODE_HALT = 2'h0;
   localparam logic [1:0] MODE_FREE = 2'h1;
   localparam logic [1:0] MODE_MODULO = 2'h2;
   localparam logic [1:0] MODE_UPDOWN = 2'h3;
   // prescale terminal counts (divide minus one)
   localparam logic [6:0] DIV1_LAST = 7'h00;
   localparam logic [6:0] DIV8_LAST = 7'h07;
   localparam logic [6:0] DIV32_LAST = 7'h1f;
   localparam logic [6:0] DIV128_LAST = 7'h7f;
   // reset values and counter landmarks
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_TOP = 16'hffff;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CMP_RESET = 16'hffff;
   localparam logic [2:0] TICK_SPEED_RESET = 3'h0;
   // bus answer states, gray ordered
   typedef enum logic [1:0] {
      STC_BUS_IDLE = 2'b00,
      STC_BUS_DONE = 2'b01
   } stc_bus_t;
endpackage

/* src/stc_timer.sv */
// sixteen-bit timer counter core with apb register slave
`timescale 1ns/1ps
`default_nettype none
module stc_timer
   import stc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out
);

   // whole module state
   typedef struct packed {
      stc_bus_t bus;
      logic [31:0] rdata;
      logic slverr;
      logic [15:0] count;
      logic count_down;
      logic [15:0] cmp;
      logic [7:0] cmp_low_stage;
      logic [7:0] high_hold;
      logic [1:0] mode;
      logic [1:0] div;
      logic [6:0] presc;
      logic [2:0] tick_speed;
      logic [6:0] tick_div;
      logic overflow_flag;
      logic cpu_timer_irq_flag;
      logic overflow_irq_mask;
      logic timer_irq_enable;
      logic irq;
   } stc_state_t;

   stc_state_t state_reg;
   stc_state_t state_next;

   // address decode, shared by read and write paths
   function automatic logic addr_known(input logic [7:0] a);
      case (a)
         ADDR_CNT_LOW, ADDR_CNT_HIGH, ADDR_CONTROL, ADDR_CMP_LOW, ADDR_CMP_HIGH,
         ADDR_STATUS, ADDR_MASK, ADDR_IRQ_EN, ADDR_TICK_SPEED: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   // prescale terminal count per select code
   function automatic logic [6:0] div_last(input logic [1:0] sel);
      case (sel)
         2'h0: div_last = DIV1_LAST;
         2'h1: div_last = DIV8_LAST;
         2'h2: div_last = DIV32_LAST;
         default: div_last = DIV128_LAST;
      endcase
   endfunction

   // global tick divider terminal: 2^speed - 1
   function automatic logic [6:0] tick_last(input logic [2:0] spd);
      tick_last = 7'((8'h01 << spd) - 8'h01);
   endfunction

   logic access;
   logic wr;
   logic rd;
   logic global_tick;
   logic timer_edge;
   logic ovf_event;
   logic [15:0] cnt_step;
   logic [7:0] wbyte;

   always_comb begin
      state_next = state_reg;
      access = psel_in && penable_in && (state_reg.bus == STC_BUS_IDLE);
      wr = access && pwrite_in && addr_known(paddr_in);
      rd = access && !pwrite_in && addr_known(paddr_in);
      wbyte = pwdata_in[7:0];
      ovf_event = 1'b0;
      cnt_step = state_reg.count;

      // bus phase: one wait cycle, then pready for exactly one cycle
      if (state_reg.bus == STC_BUS_DONE) begin
         state_next.bus = STC_BUS_IDLE;
      end else if (access) begin
         state_next.bus = STC_BUS_DONE;
      end
      state_next.slverr = access && !addr_known(paddr_in);
      // read data stands only in the pready cycle, zero otherwise
      if (access || state_reg.bus == STC_BUS_DONE) begin
         state_next.rdata = 32'h0;
      end

      // global tick from the system clock, divided by 2^speed
      global_tick = (state_reg.tick_div >= tick_last(state_reg.tick_speed));
      state_next.tick_div = global_tick ? 7'h00 : state_reg.tick_div + 7'h01;

      // [RQ2] prescaler divide
      timer_edge = 1'b0;
      if (state_reg.mode != MODE_HALT && global_tick) begin
         if (state_reg.presc >= div_last(state_reg.div)) begin
            state_next.presc = 7'h00;
            timer_edge = 1'b1;
         end else begin
            state_next.presc = state_reg.presc + 7'h01;
         end
      end

      // [RQ1] [RQ6] count only on an active edge in a nonzero mode
      if (timer_edge) begin
         case (state_reg.mode)
            MODE_FREE: begin
               // [RQ7] free run wraps after top
               cnt_step = (state_reg.count == CNT_TOP) ? CNT_ZERO : state_reg.count + CNT_ONE;
               // [RQ8] flag on reaching top
               ovf_event = (cnt_step == CNT_TOP);
            end
            MODE_MODULO: begin
               // [RQ9] wrap after the period compare value
               cnt_step = (state_reg.count == state_reg.cmp) ? CNT_ZERO
                  : state_reg.count + CNT_ONE;
               // [RQ10] flag on reaching compare
               ovf_event = (cnt_step == state_reg.cmp);
            end
            MODE_UPDOWN: begin
               // [RQ11] turn at compare, turn again at zero
               if (!state_reg.count_down) begin
                  if (state_reg.count >= state_reg.cmp) begin
                     state_next.count_down = (state_reg.count != CNT_ZERO);
                     cnt_step = (state_reg.count == CNT_ZERO) ? CNT_ZERO
                        : state_reg.count - CNT_ONE;
                  end else begin
                     cnt_step = state_reg.count + CNT_ONE;
                  end
               end else begin
                  cnt_step = state_reg.count - CNT_ONE;
                  if (cnt_step == CNT_ZERO) begin
                     state_next.count_down = 1'b0;
                  end
               end
               // [RQ12] flag only on return to zero
               ovf_event = state_reg.count_down && (cnt_step == CNT_ZERO);
            end
            default: cnt_step = state_reg.count;
         endcase
         state_next.count = cnt_step;
      end

      // register reads; data captured at the edge that raises pready
      if (rd) begin
         case (paddr_in)
            ADDR_CNT_LOW: begin
               state_next.rdata = {24'h0, state_reg.count[7:0]};
               // [RQ3] latch upper byte with the low read
               state_next.high_hold = state_reg.count[15:8];
            end
            // [RQ4] upper read returns the value latched by the low read
            ADDR_CNT_HIGH: state_next.rdata = {24'h0, state_reg.high_hold};
            ADDR_CONTROL: state_next.rdata = {28'h0, state_reg.div, state_reg.mode};
            ADDR_CMP_LOW: state_next.rdata = {24'h0, state_reg.cmp[7:0]};
            ADDR_CMP_HIGH: state_next.rdata = {24'h0, state_reg.cmp[15:8]};
            ADDR_STATUS: state_next.rdata = {30'h0, state_reg.cpu_timer_irq_flag,
               state_reg.overflow_flag};
            ADDR_MASK: state_next.rdata = {31'h0, state_reg.overflow_irq_mask};
            ADDR_IRQ_EN: state_next.rdata = {31'h0, state_reg.timer_irq_enable};
            ADDR_TICK_SPEED: state_next.rdata = {29'h0, state_reg.tick_speed};
            default: state_next.rdata = 32'h0;
         endcase
      end

      // register writes
      if (wr) begin
         case (paddr_in)
            ADDR_CNT_LOW: begin
               // [RQ5] any write clears the counter
               state_next.count = CNT_ZERO;
               state_next.count_down = 1'b0;
               state_next.presc = 7'h00;
            end
            ADDR_CONTROL: begin
               // [RQ6] [RQ15] mode and prescale codes
               state_next.mode = wbyte[MODE_LSB +: 2];
               state_next.div = wbyte[DIV_LSB +: 2];
            end
            // low compare byte waits for the high byte so the pair changes at once
            ADDR_CMP_LOW: state_next.cmp_low_stage = wbyte;
            ADDR_CMP_HIGH: state_next.cmp = {wbyte, state_reg.cmp_low_stage};
            ADDR_STATUS: begin
               if (wbyte[OVF_BIT]) begin
                  state_next.overflow_flag = 1'b0;
               end
               if (wbyte[CPU_BIT]) begin
                  state_next.cpu_timer_irq_flag = 1'b0;
               end
            end
            ADDR_MASK: state_next.overflow_irq_mask = wbyte[0];
            ADDR_IRQ_EN: state_next.timer_irq_enable = wbyte[0];
            ADDR_TICK_SPEED: state_next.tick_speed = wbyte[2:0];
            default: state_next.mode = state_reg.mode;
         endcase
      end

      // [RQ13] flags set after any clear so a same-cycle event wins
      if (ovf_event) begin
         state_next.overflow_flag = 1'b1;
      end
      // unmasking with a pending overflow raises a fresh cpu flag
      if ((ovf_event || state_next.overflow_flag) && state_next.overflow_irq_mask
            && (ovf_event || !state_reg.overflow_irq_mask)) begin
         state_next.cpu_timer_irq_flag = 1'b1;
      end

      // [RQ14] request needs both mask and enable
      state_next.irq = state_next.cpu_timer_irq_flag && state_next.overflow_irq_mask
         && state_next.timer_irq_enable;
   end

   // single state register; [RQ16] reset is halted at zero, divide by one
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg.bus <= STC_BUS_IDLE;
         state_reg.rdata <= 32'h0;
         state_reg.slverr <= 1'b0;
         state_reg.count <= CNT_ZERO;
         state_reg.count_down <= 1'b0;
         state_reg.cmp <= CMP_RESET;
         state_reg.cmp_low_stage <= 8'h00;
         state_reg.high_hold <= 8'h00;
         state_reg.mode <= MODE_HALT;
         state_reg.div <= 2'h0;
         state_reg.presc <= 7'h00;
         state_reg.tick_speed <= TICK_SPEED_RESET;
         state_reg.tick_div <= 7'h00;
         state_reg.overflow_flag <= 1'b0;
         state_reg.cpu_timer_irq_flag <= 1'b0;
         state_reg.overflow_irq_mask <= 1'b0;
         state_reg.timer_irq_enable <= 1'b0;
         state_reg.irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from state flops
   assign prdata_out = state_reg.rdata;
   assign pready_out = (state_reg.bus == STC_BUS_DONE);
   assign pslverr_out = state_reg.slverr;
   assign irq_out = state_reg.irq;

endmodule
`default_nettype wire

/* test/stc_timer_checker.sv */
// assertion checker for the timer counter bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module stc_timer_checker
   import stc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic take;
   logic hit;
   logic clr_en;
   logic clr_mask;
   // an access is taken only while the slave is idle, so a held request is seen once
   assign take = psel_in && penable_in && !pready_out;
   assign hit = (paddr_in[1:0] == 2'h0) && (paddr_in <= ADDR_TICK_SPEED);
   assign clr_en = take && pwrite_in && (paddr_in == ADDR_IRQ_EN) && !pwdata_in[0];
   assign clr_mask = take && pwrite_in && (paddr_in == ADDR_MASK) && !pwdata_in[0];
   ready_timing_a: assert property (take |=> pready_out) else $error("ready late"); // bus answer
   ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready long"); // bus
   ready_cause_a: assert property (pready_out |-> $past(take)) else $error("stray ready"); // bus
   err_unmapped_a: assert property (take && !hit |=> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped not refused"); // bus refusal
   err_mapped_a: assert property (take && hit |=> !pslverr_out) else $error("bad error"); // bus
   idle_data_a: assert property (!pready_out |-> prdata_out == 32'h0) else $error("data idle"); // bus
   irq_enable_a: assert property (clr_en |-> ##2 !irq_out) else $error("irq not off");
   irq_mask_a: assert property (clr_mask |-> ##2 !irq_out) else $error("irq masked");
   cover property (take && !hit);
   cover property ($rose(irq_out));
   cover property (take && paddr_in == ADDR_CNT_HIGH);
endmodule
bind stc_timer stc_timer_checker u_stc_timer_checker (.clk_in, .rst_n_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .irq_out);
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the timer counter
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import stc_pkg::*;
;
   logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [15:0] lfsr, cmp, ec;
   logic [1:0] md;
   logic err, fl;
   int fail_count, n_tests, k;
   int divs[4] = '{1, 8, 32, 128};
   longint t_take, t_run, n;
   stc_timer u_stc_timer (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out);
   // free running clock, 40 ns period
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t expected %h got %h", $time, exp, got);
      end
   endtask
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // counter value after n running edges from zero; up/down folds at the period value
   function automatic logic [15:0] expect_cnt(input logic [1:0] m, input longint n, input int d,
      input logic [15:0] c);
      longint q;
      q = n / d;
      if (m == MODE_FREE) return q[15:0];
      if (m == MODE_MODULO) return 16'(q % (c + 1));
      q = q % (2 * c);
      return 16'((q <= c) ? q : 2 * c - q);
   endfunction
   // one transfer; an idle cycle follows so psel is never assigned twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      for (i = 0; i < 9; i++) begin
         // look between edges so the registered outputs have settled
         @(negedge clk_in);
         if (pready_out === 1'b1) break;
         @(posedge clk_in);
      end
      if (i == 9) begin
         fail_count++;
         test_done();
      end
      rd = prdata_out;
      err = pslverr_out;
      // the edge that samples pready high; the access was taken one edge before
      @(posedge clk_in);
      t_take = $time / 40 - 1;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic check_cnt(input logic [15:0] e);
      apb(1'b0, ADDR_CNT_LOW, 32'h0);
      check({24'h0, e[7:0]}, rd);
      apb(1'b0, ADDR_CNT_HIGH, 32'h0);
      check({24'h0, e[15:8]}, rd);
   endtask
   // clear with random data, start, run for a while, halt; n is the count of running edges
   task automatic run(input logic [1:0] m, input logic [1:0] ds, input int idle);
      lfsr = step(lfsr);
      apb(1'b1, ADDR_CNT_LOW, {16'h0, lfsr});
      apb(1'b1, ADDR_STATUS, 32'h3);
      apb(1'b1, ADDR_CONTROL, {28'h0, ds, m});
      t_run = t_take;
      repeat (idle) @(posedge clk_in);
      apb(1'b1, ADDR_CONTROL, {28'h0, ds, MODE_HALT});
      n = t_take - t_run;
   endtask
   initial begin
      {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      lfsr = 16'd14226;
      fail_count = 0;
      n_tests = 0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      check_cnt(16'h0);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check(32'h0, rd);
      apb(1'b0, 8'h24, 32'h0);
      check(32'h1, {31'h0, err});
      apb(1'b1, ADDR_IRQ_EN, 32'h1);
      // every prescale setting in free mode, random run length
      for (k = 0; k < 4; k++) begin
         lfsr = step(lfsr);
         run(MODE_FREE, k[1:0], 16 + lfsr[8:0]);
         ec = expect_cnt(MODE_FREE, n, divs[k], 16'h0);
         check_cnt(ec);
      end
      repeat (40) @(posedge clk_in);
      check_cnt(ec);
      // slower global tick: divider phase is free running, so allow one step of slack
      apb(1'b1, ADDR_TICK_SPEED, 32'h3);
      run(MODE_FREE, 2'h0, 200);
      apb(1'b0, ADDR_CNT_LOW, 32'h0);
      ec = 16'(n / 8);
      check(32'h1, {31'h0, rd[7:0] == ec[7:0] || rd[7:0] == ec[7:0] + 8'h01});
      apb(1'b1, ADDR_TICK_SPEED, 32'h0);
      // modulo and up/down, random length then a length just past the period value
      for (k = 0; k < 4; k++) begin
         lfsr = step(lfsr);
         cmp = {12'h0, lfsr[3:0]} + 16'h8;
         md = k[0] ? MODE_MODULO : MODE_UPDOWN;
         apb(1'b1, ADDR_CMP_LOW, {24'h0, cmp[7:0]});
         apb(1'b1, ADDR_CMP_HIGH, {24'h0, cmp[15:8]});
         apb(1'b1, ADDR_MASK, {31'h0, k[0]});
         run(md, 2'h0, k[1] ? int'(cmp) : int'(lfsr[7:0]));
         check_cnt(expect_cnt(md, n, 1, cmp));
         fl = k[0] ? (n >= cmp) : (n >= 2 * cmp);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check({30'h0, fl & k[0], fl}, rd);
         check({31'h0, fl & k[0]}, {31'h0, irq_out});
      end
      apb(1'b1, ADDR_MASK, 32'h0);
      check(32'h0, {31'h0, irq_out});
      apb(1'b1, ADDR_MASK, 32'h1);
      check(32'h1, {31'h0, irq_out});
      apb(1'b1, ADDR_STATUS, 32'h3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(32'h0, rd);
      check(32'h0, {31'h0, irq_out});
      // high byte must stay as latched while the counter runs on
      apb(1'b1, ADDR_CNT_LOW, 32'h0);
      apb(1'b1, ADDR_CONTROL, {30'h0, MODE_FREE});
      t_run = t_take;
      repeat (300) @(posedge clk_in);
      apb(1'b0, ADDR_CNT_LOW, 32'h0);
      ec = 16'(t_take - t_run - 1);
      check({24'h0, ec[7:0]}, rd);
      repeat (300) @(posedge clk_in);
      apb(1'b0, ADDR_CNT_HIGH, 32'h0);
      check({24'h0, ec[15:8]}, rd);
      // free mode overflow near the top, then wrap; polling starts just short of the top
      repeat (64900) @(posedge clk_in);
      for (k = 0; k < 40; k++) begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         if (rd[0] === 1'b1) break;
      end
      n = t_take - t_run;
      check(32'h1, {31'h0, n >= 65536 && n <= 65540});
      check(32'h1, {31'h0, irq_out});
      apb(1'b1, ADDR_CONTROL, {30'h0, MODE_HALT});
      n = t_take - t_run;
      check_cnt(n[15:0]);
      test_done();
   end
endmodule
`default_nettype wire
